// file: verilog/macm_ctl.sv
/*
   memory controller end: apb register slave, power-up sequence into
   multiplexed address mode, two-phase command issue and data bursts.
   assumes the device shares clk and the bus is joined by macm_if.
*/
// Local design decisions: register access over APB and the address map.
// Contract
// - mode load with A5 high enters mux
// - wait recovery before two-phase mode load
// - mux mode load: A5 high, A10-A18 zero
// - dll reset field turns dll off
// - dummy mode loads drive all address low
// - init ends with eight refreshes, 1024 nops
// - address split across two clock phases
// - x9 burst two carries A21 on A5
// - mux mode adds one latency clock
// - configuration table of cycle and latencies
// - configurations only within frequency and burst
// - write then read same bank: extra clock
// - refresh executes on the following edge
// - refresh is single cycle, next follows
// - same-bank writes wait row cycle time
// - same-bank reads wait row cycle time
// - same-bank read then write waits
// - write data on successive clocks after latency
`timescale 1ns/1ps
module macm_ctl (
   input logic clk,
   input logic rstn,
   macm_if.ctl m,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [7:0] paddr,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_INIT = 3'h1,
      ST_WAIT = 3'h2,
      ST_PH2 = 3'h3,
      ST_RUN = 3'h4,
      ST_XFER = 3'h5
   } macm_st_t;

   typedef struct packed {
      macm_st_t st;
      macm_st_t ret;
      logic [3:0] step;
      logic [7:0] cnt;
      logic [4:0] e;
      logic [2:0] cfg;
      logic [1:0] bl;
      logic dll;
      logic done;
      logic cfg_err;
      logic pend;
      macm_pkg::macm_cmd_t pcmd;
      logic [2:0] pbank;
      logic [21:0] padr;
      logic [17:0] wdata;
      logic [17:0] rdata;
      macm_pkg::macm_cmd_t cmd;
      macm_pkg::macm_cmd_t xcmd;
      logic [2:0] ba;
      logic [18:0] addr;
      logic [18:0] ay;
      logic [17:0] dq_o;
      logic dq_oe;
      logic rdy;
      logic [31:0] rd;
      logic err;
   } macm_ctl_t;

   macm_ctl_t r;
   macm_ctl_t next_r;
   logic [4:0] n_el;
   logic [4:0] rl;
   logic [4:0] wl;
   logic [4:0] lat;
   logic [4:0] e1;
   logic [21:0] mra;
   logic [7:0] free;
   logic issue;
   logic [3:0] trc_ld;
   logic [2:0] new_cfg;
   logic [1:0] new_bl;

   // ************************************************
   // row cycle tracking
   // ************************************************
   assign issue = (r.cmd == macm_pkg::MACM_RD) || (r.cmd == macm_pkg::MACM_WR) ||
                  (r.cmd == macm_pkg::MACM_REF);
   // one more clock after a write in the three-clock configuration
   assign trc_ld = macm_pkg::trc_of(r.cfg) - 4'h1 +
                   {3'h0, (r.cfg == 3'h4) && (r.cmd == macm_pkg::MACM_WR)};

   macm_trc u_trc (
      .clk(clk),
      .rstn(rstn),
      .issue(issue),
      .bank(r.ba),
      .load(trc_ld),
      .free(free)
   );

   // ************************************************
   // sequencer and register slave
   // ************************************************
   always_comb begin
      next_r = r;
      n_el = macm_pkg::bl_elems(r.bl);
      rl = macm_pkg::rl_of(r.cfg);
      wl = rl + 5'h1;
      lat = (r.xcmd == macm_pkg::MACM_WR) ? wl : rl;
      e1 = r.e + 5'h1;
      mra = '0;
      mra[macm_pkg::MR_CFG_LSB +: 3] = r.cfg;
      mra[macm_pkg::MR_BL_LSB +: 2] = r.bl;
      mra[macm_pkg::MR_DLL_BIT] = r.dll;
      mra[macm_pkg::MR_MUX_BIT] = 1'b1;
      new_cfg = pwdata[2:0];
      new_bl = pwdata[macm_pkg::CTRL_BL_LSB +: 2];
      next_r.cmd = macm_pkg::MACM_NOP;
      next_r.ba = 3'h0;
      next_r.addr = '0;
      next_r.rdy = 1'b0;
      next_r.err = 1'b0;
      case (r.st)
         ST_INIT: begin
            next_r.cnt = macm_pkg::MRSC_CLK - 8'h1;
            next_r.st = ST_WAIT;
            if (r.step == 4'h0) begin
               next_r.cmd = macm_pkg::MACM_MRS;
            end else if (r.step == 4'h1) begin
               next_r.cmd = macm_pkg::MACM_MRS;
               next_r.addr = mra[18:0];
            end else if (r.step == 4'h2) begin
               next_r.cmd = macm_pkg::MACM_MRS;
               next_r.addr = macm_pkg::ax_of(mra, r.bl);
               next_r.ay = macm_pkg::ay_of(mra, r.bl);
               next_r.ret = ST_WAIT;
               next_r.st = ST_PH2;
            end else if (r.step <= 4'ha) begin
               next_r.cmd = macm_pkg::MACM_REF;
               next_r.ba = 3'(r.step - 4'h3);
               next_r.cnt = macm_pkg::REF_GAP - 8'h1;
            end else begin
               next_r.done = 1'b1;
               next_r.st = ST_RUN;
            end
         end
         ST_WAIT: begin
            next_r.cnt = r.cnt - 8'h1;
            if (r.cnt == 8'h0) begin
               next_r.step = r.step + 4'h1;
               next_r.st = ST_INIT;
            end
         end
         ST_PH2: begin
            next_r.addr = r.ay;
            next_r.e = 5'h1;
            next_r.st = r.ret;
         end
         ST_RUN: begin
            if (r.pend && free[r.pbank]) begin
               next_r.pend = 1'b0;
               next_r.cmd = r.pcmd;
               next_r.ba = r.pbank;
               if (r.pcmd != macm_pkg::MACM_REF) begin
                  next_r.xcmd = r.pcmd;
                  next_r.addr = macm_pkg::ax_of(r.padr, r.bl);
                  next_r.ay = macm_pkg::ay_of(r.padr, r.bl);
                  next_r.ret = ST_XFER;
                  next_r.st = ST_PH2;
               end
            end
         end
         ST_XFER: begin
            next_r.e = e1;
            next_r.dq_oe = (r.xcmd == macm_pkg::MACM_WR) && (e1 >= wl) && (e1 < wl + n_el);
            next_r.dq_o = r.wdata + {13'h0, e1 - wl};
            if (r.xcmd == macm_pkg::MACM_RD && r.e == rl) begin
               next_r.rdata = m.dq;
            end
            if (e1 >= lat + n_el) begin
               next_r.dq_oe = 1'b0;
               next_r.st = ST_RUN;
            end
         end
         default: begin
         end
      endcase
      // apb: one wait state, answer registered
      if (psel && penable && !r.rdy) begin
         next_r.rdy = 1'b1;
         next_r.rd = 32'h0;
         case (paddr)
            macm_pkg::REG_CTRL: begin
               next_r.rd = {23'h0, 1'b0, 2'h0, r.dll, r.bl, r.cfg};
               if (pwrite && r.st == ST_IDLE) begin
                  next_r.cfg = new_cfg;
                  next_r.bl = new_bl;
                  next_r.dll = pwdata[macm_pkg::CTRL_DLL_BIT];
                  if (pwdata[macm_pkg::CTRL_GO_BIT]) begin
                     next_r.cfg_err = !macm_pkg::cfg_ok(new_cfg, new_bl);
                     next_r.step = 4'h0;
                     if (macm_pkg::cfg_ok(new_cfg, new_bl)) begin
                        next_r.st = ST_INIT;
                     end
                  end
               end
            end
            macm_pkg::REG_CMD: begin
               next_r.rd = {25'h0, r.pbank, 1'b0, r.pcmd};
               if (pwrite && !r.pend) begin
                  next_r.pcmd = macm_pkg::macm_cmd_t'(pwdata[2:0]);
                  next_r.pbank = pwdata[macm_pkg::CMD_BANK_LSB +: 3];
                  next_r.pend = (pwdata[2:0] == 3'h1) || (pwdata[2:0] == 3'h2) || (pwdata[2:0] == 3'h4);
               end
            end
            macm_pkg::REG_ADDR: begin
               next_r.rd = {10'h0, r.padr};
               if (pwrite) begin
                  next_r.padr = pwdata[21:0];
               end
            end
            macm_pkg::REG_WDATA: begin
               next_r.rd = {14'h0, r.wdata};
               if (pwrite) begin
                  next_r.wdata = pwdata[17:0];
               end
            end
            macm_pkg::REG_RDATA: begin
               next_r.rd = {14'h0, r.rdata};
            end
            macm_pkg::REG_STATUS: begin
               next_r.rd = {29'h0, r.cfg_err, r.done, r.pend || (r.st != ST_RUN)};
            end
            default: begin
               next_r.err = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // ************************************************
   // outputs
   // ************************************************
   assign m.cmd = r.cmd;
   assign m.ba = r.ba;
   assign m.addr = r.addr;
   assign m.dq_ctl = r.dq_o;
   assign m.dq_ctl_oe = r.dq_oe;
   assign prdata = r.rd;
   assign pready = r.rdy;
   assign pslverr = r.err;
endmodule : macm_ctl

// file: verilog/macm_pkg.sv
/*
   shared constants, types and address-phase functions of the multiplexed
   address command mode.
   assumes both ends are built for the same data width, set below.
*/
package macm_pkg;

   // ************************************************
   // sizes and command codes
   // ************************************************
   localparam int DQ_W = 18;
   localparam int BALL_W = 19;
   localparam int ADR_W = 22;
   localparam int NBANK = 8;
   typedef enum logic [2:0] {
      MACM_NOP = 3'h0,
      MACM_RD = 3'h1,
      MACM_WR = 3'h2,
      MACM_MRS = 3'h3,
      MACM_REF = 3'h4
   } macm_cmd_t;
   typedef enum logic [1:0] {MACM_X9 = 2'h0, MACM_X18 = 2'h1, MACM_X36 = 2'h2} macm_width_t;
   localparam macm_width_t DEV_WIDTH = MACM_X18;
   localparam logic [1:0] BL2 = 2'h0;
   localparam logic [1:0] BL4 = 2'h1;
   localparam logic [1:0] BL8 = 2'h2;

   // ************************************************
   // mode register fields and timing
   // ************************************************
   localparam int MR_CFG_LSB = 0;
   localparam int MR_BL_LSB = 3;
   localparam int MR_MUX_BIT = 5;
   localparam int MR_DLL_BIT = 7;
   localparam int MR_IGN_BALL = 8;
   localparam logic [7:0] MRSC_CLK = 8'h06;
   localparam int INIT_NOP_TOTAL = 1024;
   localparam logic [7:0] REF_GAP = 8'(INIT_NOP_TOTAL / NBANK);
   localparam logic [4:0][3:0] TRC_TAB = {4'h5, 4'h3, 4'h8, 4'h6, 4'h4};
   localparam logic [4:0][3:0] RL_TAB = {4'h6, 4'h4, 4'h9, 4'h7, 4'h5};
   localparam logic [4:0][9:0] FMAX_TAB = {10'h14d, 10'h0c8, 10'h215, 10'h190, 10'h10a};
   localparam logic [9:0] FMIN_MHZ = 10'h0af;
   localparam logic [9:0] MEM_CK_MHZ = 10'h0c8;
   localparam logic [18:0] AX_BALLS = 19'h66739;

   // ************************************************
   // apb register map of the controller
   // ************************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CMD = 8'h04;
   localparam logic [7:0] REG_ADDR = 8'h08;
   localparam logic [7:0] REG_WDATA = 8'h0c;
   localparam logic [7:0] REG_RDATA = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam int CTRL_BL_LSB = 3;
   localparam int CTRL_DLL_BIT = 5;
   localparam int CTRL_GO_BIT = 8;
   localparam int CMD_BANK_LSB = 4;

   // ************************************************
   // functions
   // ************************************************
   function automatic logic [4:0] bl_elems(logic [1:0] bl);
      return (bl == BL2) ? 5'h2 : (bl == BL4) ? 5'h4 : 5'h8;
   endfunction : bl_elems

   function automatic logic [3:0] trc_of(logic [2:0] c);
      return (c >= 3'h1 && c <= 3'h5) ? TRC_TAB[c - 3'h1] : 4'h8;
   endfunction : trc_of

   function automatic logic [4:0] rl_of(logic [2:0] c);
      return (c >= 3'h1 && c <= 3'h5) ? {1'b0, RL_TAB[c - 3'h1]} : 5'h9;
   endfunction : rl_of

   function automatic logic cfg_ok(logic [2:0] c, logic [1:0] bl);
      if (c < 3'h1 || c > 3'h5 || bl > BL8) return 1'b0;
      if (bl == BL8 && (c == 3'h1 || c == 3'h4)) return 1'b0;
      return MEM_CK_MHZ >= FMIN_MHZ && MEM_CK_MHZ <= FMAX_TAB[c - 3'h1];
   endfunction : cfg_ok

   function automatic logic a18_used(logic [1:0] bl);
      return !(DEV_WIDTH == MACM_X36 && bl == BL8);
   endfunction : a18_used

   function automatic logic a19_used(logic [1:0] bl);
      if (DEV_WIDTH == MACM_X36) return bl == BL2;
      if (DEV_WIDTH == MACM_X18) return bl != BL8;
      return 1'b1;
   endfunction : a19_used

   function automatic logic a20_used(logic [1:0] bl);
      if (DEV_WIDTH == MACM_X18) return bl == BL2;
      if (DEV_WIDTH == MACM_X9) return bl != BL8;
      return 1'b0;
   endfunction : a20_used

   function automatic logic [18:0] ax_of(logic [21:0] a, logic [1:0] bl);
      logic [18:0] x;
      x = a[18:0] & AX_BALLS;
      x[18] = x[18] & a18_used(bl);
      return x;
   endfunction : ax_of

   function automatic logic [18:0] ay_of(logic [21:0] a, logic [1:0] bl);
      logic [18:0] y;
      y = '0;
      y[0] = a[20] & a20_used(bl);
      y[3] = a[1];
      y[4] = a[2];
      y[5] = a[21] & (DEV_WIDTH == MACM_X9) & (bl == BL2);
      y[8] = a[6];
      y[9] = a[7];
      y[10] = a[19] & a19_used(bl);
      y[13] = a[11];
      y[14] = a[12];
      y[17] = a[16];
      y[18] = a[15];
      return y;
   endfunction : ay_of

   function automatic logic [21:0] join_of(logic [18:0] x, logic [18:0] y, logic [1:0] bl);
      logic [21:0] a;
      a = {3'h0, ax_of({3'h0, x}, bl)};
      a[1] = y[3];
      a[2] = y[4];
      a[6] = y[8];
      a[7] = y[9];
      a[11] = y[13];
      a[12] = y[14];
      a[15] = y[18];
      a[16] = y[17];
      a[19] = y[10] & a19_used(bl);
      a[20] = y[0] & a20_used(bl);
      a[21] = y[5] & (DEV_WIDTH == MACM_X9) & (bl == BL2);
      return a;
   endfunction : join_of

endpackage : macm_pkg

// file: verilog/macm_if.sv
/*
   command, address and data pins between controller and memory device.
   assumes both ends run on the same clock; the shared data bus is resolved here.
*/
`timescale 1ns/1ps
interface macm_if;
   macm_pkg::macm_cmd_t cmd;
   logic [2:0] ba;
   logic [18:0] addr;
   logic [17:0] dq_ctl;
   logic dq_ctl_oe;
   logic [17:0] dq_dev;
   logic dq_dev_oe;
   logic [17:0] dq;

   assign dq = dq_dev_oe ? dq_dev : (dq_ctl_oe ? dq_ctl : '0);

   modport ctl (output cmd, output ba, output addr, output dq_ctl, output dq_ctl_oe, input dq);
   modport dev (input cmd, input ba, input addr, input dq, output dq_dev, output dq_dev_oe);
endinterface : macm_if

// file: verilog/macm_trc.sv
/*
   per-bank row cycle tracker for the controller.
   assumes issue is high in the cycle a bank command stands on the pins.
*/
`timescale 1ns/1ps
module macm_trc (
   input logic clk,
   input logic rstn,
   input logic issue,
   input logic [2:0] bank,
   input logic [3:0] load,
   output logic [7:0] free
);
   logic [7:0][3:0] cnt;
   logic [7:0][3:0] next_cnt;

   always_comb begin
      for (int b = 0; b < 8; b++) begin
         next_cnt[b] = (cnt[b] != 4'h0) ? cnt[b] - 4'h1 : 4'h0;
         if (issue && bank == 3'(b)) begin
            next_cnt[b] = load;
         end
         // free one cycle ahead so the next command lands on the limit
         free[b] = (cnt[b] <= 4'h1) && !(issue && bank == 3'(b));
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end
endmodule : macm_trc

// file: verilog/macm_dev.sv
/*
   memory device end: command decode in plain and multiplexed address mode,
   mode register, latency timing and a small array of data words.
   assumes the controller serialises reads and writes.
*/
`timescale 1ns/1ps
module macm_dev (
   input logic clk,
   input logic rstn,
   macm_if.dev m,
   output logic mux_mode,
   output logic dll_on,
   output logic [2:0] mode_cfg,
   output logic [1:0] mode_bl,
   output logic ref_pulse,
   output logic [2:0] ref_bank
);
   typedef struct packed {
      logic mux;
      logic dll;
      logic [2:0] cfg;
      logic [1:0] bl;
      logic ph2;
      macm_pkg::macm_cmd_t pcmd;
      logic [2:0] pbank;
      logic [18:0] pax;
      logic busy;
      logic wr;
      logic [3:0] d;
      logic [3:0] k;
      logic [21:0] a;
      logic [17:0] dq_o;
      logic dq_oe;
      logic refp;
      logic [2:0] refb;
      logic [15:0][17:0] mem;
   } macm_dev_t;

   macm_dev_t r;
   macm_dev_t next_r;
   macm_pkg::macm_cmd_t ecmd;
   logic [21:0] ea;
   logic [2:0] eb;
   logic [18:0] ay;
   logic take;
   logic [4:0] lat;
   logic [3:0] idx;
   logic [4:0] n_el;

   // ************************************************
   // command decode and execution
   // ************************************************
   always_comb begin
      next_r = r;
      next_r.refp = 1'b0;
      ecmd = macm_pkg::MACM_NOP;
      ea = '0;
      eb = r.pbank;
      ay = m.addr;
      take = 1'b1;
      n_el = macm_pkg::bl_elems(r.bl);
      idx = r.a[3:0] + r.k;
      if (r.ph2) begin
         next_r.ph2 = 1'b0;
         ecmd = r.pcmd;
         if (r.pcmd == macm_pkg::MACM_MRS) begin
            ay[macm_pkg::MR_IGN_BALL] = 1'b0;
         end
         ea = macm_pkg::join_of(r.pax, ay, r.bl);
         take = (r.pcmd == macm_pkg::MACM_REF);
      end
      if (take && m.cmd != macm_pkg::MACM_NOP) begin
         if (r.mux) begin
            next_r.ph2 = 1'b1;
            next_r.pcmd = m.cmd;
            next_r.pbank = m.ba;
            next_r.pax = m.addr;
         end else begin
            ecmd = m.cmd;
            ea = {3'h0, m.addr};
            eb = m.ba;
         end
      end
      // data phase of the running burst
      if (r.busy) begin
         if (r.d != 4'h0) begin
            next_r.d = r.d - 4'h1;
            if (r.d == 4'h1 && !r.wr) begin
               next_r.dq_oe = 1'b1;
               next_r.dq_o = r.mem[r.a[3:0]];
               next_r.k = 4'h1;
            end
         end else if (r.wr) begin
            next_r.mem[idx] = m.dq;
            next_r.k = r.k + 4'h1;
            if ({1'b0, r.k} == n_el - 5'h1) begin
               next_r.busy = 1'b0;
            end
         end else if ({1'b0, r.k} == n_el) begin
            next_r.dq_oe = 1'b0;
            next_r.busy = 1'b0;
         end else begin
            next_r.dq_o = r.mem[idx];
            next_r.k = r.k + 4'h1;
         end
      end
      lat = macm_pkg::rl_of(r.cfg) - (r.mux ? 5'h0 : 5'h1);
      if (ecmd == macm_pkg::MACM_WR) begin
         lat = lat + 5'h1;
      end
      case (ecmd)
         macm_pkg::MACM_MRS: begin
            next_r.mux = r.mux | ea[macm_pkg::MR_MUX_BIT];
            next_r.cfg = ea[macm_pkg::MR_CFG_LSB +: 3];
            next_r.bl = ea[macm_pkg::MR_BL_LSB +: 2];
            next_r.dll = !ea[macm_pkg::MR_DLL_BIT];
         end
         macm_pkg::MACM_REF: begin
            next_r.refp = 1'b1;
            next_r.refb = eb;
         end
         macm_pkg::MACM_RD, macm_pkg::MACM_WR: begin
            if (!r.busy) begin
               next_r.busy = 1'b1;
               next_r.wr = (ecmd == macm_pkg::MACM_WR);
               next_r.a = ea;
               next_r.k = 4'h0;
               next_r.d = 4'(lat - (r.mux ? 5'h2 : 5'h1));
            end
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign m.dq_dev = r.dq_o;
   assign m.dq_dev_oe = r.dq_oe;
   assign mux_mode = r.mux;
   assign dll_on = r.dll;
   assign mode_cfg = r.cfg;
   assign mode_bl = r.bl;
   assign ref_pulse = r.refp;
   assign ref_bank = r.refb;
endmodule : macm_dev

// file: dv/macm_checker.sv
/*
   assertions on the pins between controller and device.
   assumes it sits beside the interface and shares its clock and reset.
*/
`timescale 1ns/1ps
module macm_checker (
   input logic clk,
   input logic rstn,
   input macm_pkg::macm_cmd_t cmd,
   input logic [2:0] ba,
   input logic [18:0] addr,
   input logic dq_ctl_oe,
   input logic dq_dev_oe
);
   // ************************
   // pin rules
   // ************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   logic bank_cmd;
   assign bank_cmd = cmd inside {3'h1, 3'h2, 3'h4};

   AST_PHASE2_QUIET: assert property (cmd inside {3'h1, 3'h2, 3'h3} |=> cmd == macm_pkg::MACM_NOP)
      else $error("command on a second phase clock");
   AST_MODE_RECOVERY: assert property (cmd == macm_pkg::MACM_MRS |=> (cmd == macm_pkg::MACM_NOP)[*5])
      else $error("command inside mode load recovery");
   AST_MUX_LOAD_ZERO: assert property (cmd == macm_pkg::MACM_MRS && addr[5] |-> addr[18:10] == 9'h0)
      else $error("high address bits set in mode load");
   AST_DUMMY_LOAD_LOW: assert property (cmd == macm_pkg::MACM_MRS && !addr[5] |-> addr == 19'h0)
      else $error("dummy mode load with address set");
   AST_SPLIT_BALLS: assert property (cmd inside {3'h1, 3'h2} |-> (addr & ~macm_pkg::AX_BALLS) == 19'h0
      ##1 (addr & ~macm_pkg::AX_BALLS) == 19'h0)
      else $error("address on an unused ball");
   AST_READ_LATENCY: assert property (cmd == macm_pkg::MACM_RD |-> ##[4:10] dq_dev_oe)
      else $error("no read data within latency");
   AST_WRITE_LATENCY: assert property (cmd == macm_pkg::MACM_WR |-> ##[5:11] dq_ctl_oe)
      else $error("no write data within latency");
   AST_SAME_BANK_GAP: assert property (bank_cmd |=> !(bank_cmd && ba == $past(ba))
      ##1 !(bank_cmd && ba == $past(ba, 2)))
      else $error("same bank command inside row cycle");
   AST_ONE_DRIVER: assert property (!(dq_ctl_oe && dq_dev_oe))
      else $error("both ends drive the data bus");
   AST_BURST_MIN: assert property ($rose(dq_dev_oe) |-> dq_dev_oe[*2])
      else $error("read burst shorter than two");

   cover property (cmd == macm_pkg::MACM_REF);
   cover property (cmd == macm_pkg::MACM_RD);
   cover property (cmd == macm_pkg::MACM_WR);
   cover property (cmd == macm_pkg::MACM_MRS && addr[5]);
endmodule : macm_checker

// file: dv/muxed_address_cmd_mode_test.sv
/*
   self-checking bench: both ends joined by the interface, apb driven here.
   assumes the package is built for one data width and 200 MHz memory clock.
*/
`timescale 1ns/1ps
module muxed_address_cmd_mode_test;
   typedef struct {logic [21:0] a; logic [2:0] b; logic [17:0] d;} macm_row_t;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, mux_mode, dll_on, ref_pulse;
   logic [2:0] mode_cfg, ref_bank;
   logic [1:0] mode_bl, oe_q;
   int fails = 0, total_checks = 0, refs = 0, t_cmd = 0, lat = 0, wlat = 0, burst = 0, cyc = 0;
   int bank_gap = 0;
   int last_cmd[8];
   macm_row_t rows[4] = '{'{22'h000000, 3'h0, 18'h00011}, '{22'h2aaaa5, 3'h7, 18'h2a5a5},
      '{22'h15555a, 3'h3, 18'h15a5a}, '{22'h3fffff, 3'h5, 18'h3fff0}};

   macm_if m ();
   macm_ctl macm_ctl_i (.clk(clk), .rstn(rstn), .m(m), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   macm_dev macm_dev_i (.clk(clk), .rstn(rstn), .m(m), .mux_mode(mux_mode), .dll_on(dll_on),
      .mode_cfg(mode_cfg), .mode_bl(mode_bl), .ref_pulse(ref_pulse), .ref_bank(ref_bank));
   macm_checker macm_checker_i (.clk(clk), .rstn(rstn), .cmd(m.cmd), .ba(m.ba), .addr(m.addr),
      .dq_ctl_oe(m.dq_ctl_oe), .dq_dev_oe(m.dq_dev_oe));

   always #25 clk = ~clk;

   // ************************
   // pin monitor: latencies and burst length
   // ************************
   always @(posedge clk) begin
      cyc <= cyc + 1;
      oe_q <= {m.dq_ctl_oe, m.dq_dev_oe};
      if (ref_pulse === 1'b1) refs <= refs + 1;
      // spacing between commands to one bank
      if (m.cmd inside {macm_pkg::MACM_RD, macm_pkg::MACM_WR, macm_pkg::MACM_REF}) begin
         bank_gap <= cyc - last_cmd[m.ba];
         last_cmd[m.ba] <= cyc;
      end
      if (m.cmd inside {macm_pkg::MACM_RD, macm_pkg::MACM_WR}) begin
         t_cmd <= cyc;
         burst <= 0;
      end else if (m.dq_dev_oe === 1'b1) burst <= burst + 1;
      if (m.dq_dev_oe === 1'b1 && oe_q[0] !== 1'b1) lat <= cyc - t_cmd;
      if (m.dq_ctl_oe === 1'b1 && oe_q[1] !== 1'b1) wlat <= cyc - t_cmd;
   end

   // ************************
   // tasks
   // ************************
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   task automatic chk_v(input string what, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk_v

   task automatic chk_n(input string what, input int got, input int exp);
      total_checks++;
      if (got != exp) begin
         fails++;
         $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
      end
   endtask : chk_n

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      chk_v("apb answer", pready, 1'b1);
      if (pready !== 1'b1) test_done();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic wait_st(input int b, input logic v, input int lim);
      int n;
      n = 0;
      do begin
         apb(1'b0, macm_pkg::REG_STATUS, 32'h0);
         n++;
      end while (rd[b] !== v && n < lim);
      chk_v("status bit", rd[b], v);
      if (rd[b] !== v) test_done();
   endtask : wait_st

   // ************************
   // main sequence
   // ************************
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk_v("mux mode after reset", mux_mode, 1'b0);
      apb(1'b1, macm_pkg::REG_CTRL, 32'h109);
      wait_st(1, 1'b1, 500);
      chk_n("refreshes", refs, 8);
      chk_v("last refresh bank", ref_bank, 3'h7);
      chk_v("mode", {mux_mode, dll_on, mode_cfg, mode_bl}, 7'h65);
      foreach (rows[i]) begin
         apb(1'b1, macm_pkg::REG_ADDR, {10'h0, rows[i].a});
         apb(1'b1, macm_pkg::REG_WDATA, {14'h0, rows[i].d});
         apb(1'b1, macm_pkg::REG_CMD, {25'h0, rows[i].b, 4'h2});
         wait_st(0, 1'b0, 20);
         chk_n("write latency", wlat, 6);
         apb(1'b1, macm_pkg::REG_CMD, {25'h0, rows[i].b, 4'h1});
         wait_st(0, 1'b0, 20);
         apb(1'b0, macm_pkg::REG_RDATA, 32'h0);
         chk_v("read data", rd, {14'h0, rows[i].d});
         chk_n("read latency", lat, 5);
         chk_n("read burst", burst, 4);
         $display("row %0d done", i);
      end
      // refresh then read to one bank: the read waits out the row cycle
      apb(1'b1, macm_pkg::REG_CMD, 32'h24);
      apb(1'b1, macm_pkg::REG_CMD, 32'h21);
      wait_st(0, 1'b0, 20);
      chk_n("same bank gap", bank_gap, 4);
      $display("same bank spacing test done");
      apb(1'b0, 8'h3c, 32'h0);
      chk_v("unmapped error", err, 1'b1);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      chk_v("mux mode in reset", {mux_mode, dll_on}, 2'h0);
      rstn <= 1'b1;
      @(posedge clk);
      apb(1'b1, macm_pkg::REG_CTRL, 32'h114);
      wait_st(2, 1'b1, 10);
      chk_v("mux mode after refused start", mux_mode, 1'b0);
      $display("reset and refusal tests done");
      test_done();
   end
endmodule : muxed_address_cmd_mode_test
